/* File: ocpm_regs.sv */
// ocpm_regs.sv: phase offset, oscillator select, revision and pin maps
// assumes: host port and pins synchronous to clk_i
//
// Contract
// - low 13 bits of phase register are signed whole-period shift
// - negative count delays outputs, positive count advances them
// - each post divider has its own phase register for all its clocks
// - top three bits add a 45-degree quadrature step
// - codes 000,001,010,100,101,110,111 give 0,-45,-90,180,135,90,45
// - code 011 gives -135 degrees
// - oscillator select bit 0 clear enables driver, set disables it
// - revision byte is fixed; full revision adds bits 6:5 of 0x00
// - pin map low seven bits index a 128-bit table
// - pin map bit 7: 0 control input, 1 status output
// - pin maps 0,1 reset unused; pin map 2 resets to 0x60
`timescale 1ns/10ps
`include "ocpm_map.svh"
module ocpm_regs
  import ocpm_pkg::*;
#(
  parameter ocpm_byte_t REV_CODE = `OCPM_REV_DEFAULT // arbitrary value
)
(
  // clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  // host byte port
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire ocpm_byte_t   reg_addr_i,
  input  wire ocpm_byte_t   reg_wdata_i,
  output ocpm_byte_t        reg_rdata_o,
  output logic              reg_rvalid_o,
  // phase outputs: 0 synth0 div d, 1 synth1 div c, 2 synth1 div d
  output ocpm_coarse_t      ph_coarse_o [3],
  output ocpm_deg_t         ph_quad_deg_o [3],
  output logic [2:0]        ph_delay_o,
  output logic [2:0]        ph_advance_o,
  output logic [2:0]        ph_update_o,
  // oscillator and revision
  output logic              osc_drv_en_o,
  input  wire logic [1:0]   chip_rev_hi_i,
  output logic [9:0]        full_revision_o,
  // general-purpose pins and tables
  input  wire logic [2:0]   pin_i,
  output logic [2:0]        pin_o,
  output logic [2:0]        pin_oe_o,
  input  wire logic [127:0] stat_table_i,
  output logic [127:0]      ctrl_table_o
);

  ////////////////////////////////////////////////////////////////////
  // phase register address table
  localparam ocpm_byte_t PH_HI [3] = '{`OCPM_ADDR_S0D_HI,
                                       `OCPM_ADDR_S1C_HI,
                                       `OCPM_ADDR_S1D_HI};
  localparam ocpm_byte_t PH_LO [3] = '{`OCPM_ADDR_S0D_LO,
                                       `OCPM_ADDR_S1C_LO,
                                       `OCPM_ADDR_S1D_LO};

  logic [15:0] ph_act_q [3];
  logic [15:0] ph_stg_q [3];
  logic [1:0]  ph_got_q [3];

  ////////////////////////////////////////////////////////////////////
  // phase registers, one per post divider
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ph
      wire         hit_hi = reg_wr_i && (reg_addr_i == PH_HI[g]);
      wire         hit_lo = reg_wr_i && (reg_addr_i == PH_LO[g]);
      wire [15:0]  stg_d  = {hit_hi ? reg_wdata_i : ph_stg_q[g][15:8],
                             hit_lo ? reg_wdata_i : ph_stg_q[g][7:0]};
      wire [1:0]   got_d  = ph_got_q[g] | {hit_hi, hit_lo};
      wire         done_w = (got_d == 2'b11);
      ocpm_coarse_t crs_w;
      ocpm_quad_t   qd_w;

      // stage bytes, commit the pair at once
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
        begin
          ph_stg_q[g]    <= `OCPM_PHASE_RST;
          ph_act_q[g]    <= `OCPM_PHASE_RST;
          ph_got_q[g]    <= 2'b00;
          ph_update_o[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          ph_stg_q[g]    <= stg_d;
          ph_got_q[g]    <= done_w ? 2'b00 : got_d;
          ph_update_o[g] <= done_w;
          if (done_w)
          begin
            ph_act_q[g] <= stg_d;
          end
        end
      end

      // field decode of the active value
      assign crs_w = ph_act_q[g][`OCPM_COARSE_MSB:0];
      assign qd_w  = ph_act_q[g][15:`OCPM_QUAD_LSB];
      assign ph_coarse_o[g]   = crs_w;
      assign ph_quad_deg_o[g] = ocpm_quad_deg(qd_w);
      assign ph_delay_o[g]    = crs_w < 0;
      assign ph_advance_o[g]  = crs_w > 0;

      a_phase_pair_commit:
      assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && hit_lo && !hit_hi && ph_got_q[g] == 2'b10) |=>
          (ph_update_o[g] && ph_act_q[g] ==
           {$past(ph_stg_q[g][15:8]), $past(reg_wdata_i)}))
      else $error("phase pair not committed");

      a_phase_half_hold:
      assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && hit_hi && !hit_lo && ph_got_q[g] == 2'b00) |=>
          (!ph_update_o[g] && $stable(ph_act_q[g])))
      else $error("phase applied after one byte");

      a_coarse_dir:
      assert property (@(posedge clk_i) disable iff (srst_i)
        ph_update_o[g] |->
          (ph_delay_o[g] == ph_act_q[g][`OCPM_COARSE_MSB]) &&
          (ph_advance_o[g] == (!ph_act_q[g][`OCPM_COARSE_MSB] &&
                               ph_act_q[g][11:0] != 12'h000)))
      else $error("coarse direction wrong");

      a_quad_code_map:
      assert property (@(posedge clk_i) disable iff (srst_i)
        (qd_w == 3'b011 |-> ph_quad_deg_o[g] == -9'sd135) and
        (qd_w == 3'b101 |-> ph_quad_deg_o[g] == 9'sd135) and
        (qd_w == 3'b001 |-> ph_quad_deg_o[g] == -9'sd45))
      else $error("quadrature decode wrong");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // oscillator select and pin map registers
  logic       osc_q;
  ocpm_byte_t pin_map_q [3];

  wire wr_osc = reg_wr_i && (reg_addr_i == `OCPM_ADDR_OSC_SEL);
  wire wr_p0  = reg_wr_i && (reg_addr_i == `OCPM_ADDR_PIN0);
  wire wr_p1  = reg_wr_i && (reg_addr_i == `OCPM_ADDR_PIN1);
  wire wr_p2  = reg_wr_i && (reg_addr_i == `OCPM_ADDR_PIN2);

  // byte writes; reserved oscillator bits are not stored
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      osc_q        <= 1'(`OCPM_OSC_RST);
      pin_map_q[0] <= `OCPM_PIN01_RST;
      pin_map_q[1] <= `OCPM_PIN01_RST;
      pin_map_q[2] <= `OCPM_PIN2_RST;
    end
    else if (ce_i)
    begin
      if (wr_osc)
        osc_q <= reg_wdata_i[`OCPM_OSC_DIS_BIT];
      if (wr_p0)
        pin_map_q[0] <= reg_wdata_i;
      if (wr_p1)
        pin_map_q[1] <= reg_wdata_i;
      if (wr_p2)
        pin_map_q[2] <= reg_wdata_i;
    end
  end

  // driver enabled while the select bit is clear
  assign osc_drv_en_o = !osc_q;
  // revision byte joined with the two high bits from register 0x00
  assign full_revision_o = {chip_rev_hi_i, REV_CODE};

  ////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the request
  ocpm_byte_t rd_mux;

  always_comb
  begin
    rd_mux = `OCPM_UNMAPPED_RD;
    case (reg_addr_i)
      `OCPM_ADDR_S0D_HI:  rd_mux = ph_act_q[0][15:8];
      `OCPM_ADDR_S0D_LO:  rd_mux = ph_act_q[0][7:0];
      `OCPM_ADDR_OSC_SEL: rd_mux = {7'h00, osc_q};
      `OCPM_ADDR_REV:     rd_mux = REV_CODE;
      `OCPM_ADDR_S1C_HI:  rd_mux = ph_act_q[1][15:8];
      `OCPM_ADDR_S1C_LO:  rd_mux = ph_act_q[1][7:0];
      `OCPM_ADDR_S1D_HI:  rd_mux = ph_act_q[2][15:8];
      `OCPM_ADDR_S1D_LO:  rd_mux = ph_act_q[2][7:0];
      `OCPM_ADDR_PIN0:    rd_mux = pin_map_q[0];
      `OCPM_ADDR_PIN1:    rd_mux = pin_map_q[1];
      `OCPM_ADDR_PIN2:    rd_mux = pin_map_q[2];
      default:            rd_mux = `OCPM_UNMAPPED_RD;
    endcase
  end

  // registered read data
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pins and control table
  logic [2:0] c_we;
  logic [6:0] c_idx [3];

  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_pin
      ocpm_pin_map u_pin (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .ce_i         (ce_i),
        .map_i        (pin_map_q[p]),
        .stat_table_i (stat_table_i),
        .pin_i        (pin_i[p]),
        .pin_o        (pin_o[p]),
        .pin_oe_o     (pin_oe_o[p]),
        .ctrl_we_o    (c_we[p]),
        .ctrl_idx_o   (c_idx[p])
      );
    end
  endgenerate

  // control bits follow their pins; higher pin wins on a shared index
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ctrl_table_o <= 128'h0;
    else
      for (int i = 0; i < 3; i++)
        if (c_we[i])
          ctrl_table_o[c_idx[i]] <= pin_i[i];
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_osc_drv_sel:
  assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && wr_osc) |=>
      (osc_drv_en_o == !$past(reg_wdata_i[0])))
  else $error("oscillator driver enable wrong");

  a_pin2_reset_val:
  assert property (@(posedge clk_i)
    $fell(srst_i) |-> (pin_map_q[2] == 8'h60 && pin_map_q[0] == 8'h00
                       && !ctrl_table_o[96]))
  else $error("pin map reset value wrong");

  a_rev_read_fixed:
  assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && reg_rd_i && reg_addr_i == `OCPM_ADDR_REV) |=>
      (reg_rvalid_o && reg_rdata_o == REV_CODE))
  else $error("revision read wrong");

  a_ctrl_bit_follow:
  assert property (@(posedge clk_i) disable iff (srst_i)
    (c_we[2] && c_idx[2] == 7'h60) |=>
      (ctrl_table_o[96] == $past(pin_i[2])))
  else $error("control bit did not follow pin");

endmodule

/* File: ocpm_map.svh */
// ocpm_map.svh: offsets, field positions and reset values of the
// output phase and pin map register slice
// assumes: included by the design modules and the bench
`ifndef OCPM_MAP_SVH
`define OCPM_MAP_SVH

////////////////////////////////////////////////////////////////////////
// byte offsets on the host port
`define OCPM_ADDR_S0D_HI   8'hc1
`define OCPM_ADDR_S0D_LO   8'hc2
`define OCPM_ADDR_OSC_SEL  8'hc3
`define OCPM_ADDR_REV      8'hc6
`define OCPM_ADDR_S1C_HI   8'hc7
`define OCPM_ADDR_S1C_LO   8'hc8
`define OCPM_ADDR_S1D_HI   8'hc9
`define OCPM_ADDR_S1D_LO   8'hca
`define OCPM_ADDR_PIN0     8'he0
`define OCPM_ADDR_PIN1     8'he1
`define OCPM_ADDR_PIN2     8'he2

////////////////////////////////////////////////////////////////////////
// field positions
`define OCPM_COARSE_MSB    12
`define OCPM_QUAD_LSB      13
`define OCPM_OSC_DIS_BIT   0
`define OCPM_ROLE_BIT      7
`define OCPM_IDX_MSB       6

////////////////////////////////////////////////////////////////////////
// reset values
`define OCPM_PHASE_RST     16'h0000
`define OCPM_OSC_RST       8'h00
`define OCPM_PIN01_RST     8'h00
`define OCPM_PIN2_RST      8'h60
`define OCPM_MAP_UNUSED    8'h00
`define OCPM_UNMAPPED_RD   8'h00
// revision byte: value is arbitrary
`define OCPM_REV_DEFAULT   8'ha5

`endif

/* File: ocpm_pkg.sv */
// ocpm_pkg.sv: types and the quadrature decode for the phase slice
// assumes: nothing beyond the map header
package ocpm_pkg;

  typedef logic signed [12:0] ocpm_coarse_t;
  typedef logic [2:0]         ocpm_quad_t;
  typedef logic signed [8:0]  ocpm_deg_t;
  typedef logic [7:0]         ocpm_byte_t;

  // quadrature code to signed degrees
  function automatic ocpm_deg_t ocpm_quad_deg(input ocpm_quad_t code);
    ocpm_deg_t d;
    d = 9'sd0;
    case (code)
      3'b000:  d = 9'sd0;
      3'b001:  d = -9'sd45;
      3'b010:  d = -9'sd90;
      3'b011:  d = -9'sd135;
      3'b100:  d = 9'sd180;
      3'b101:  d = 9'sd135;
      3'b110:  d = 9'sd90;
      3'b111:  d = 9'sd45;
      default: d = 9'sd0;
    endcase
    return d;
  endfunction

endpackage

/* File: ocpm_pin_map.sv */
// ocpm_pin_map.sv: one general-purpose pin steered by its map byte
// assumes: pin and status table synchronous to clk_i
`timescale 1ns/10ps
`include "ocpm_map.svh"
module ocpm_pin_map
  import ocpm_pkg::*;
(
  // clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  // map byte and tables
  input  wire ocpm_byte_t   map_i,
  input  wire logic [127:0] stat_table_i,
  // pin
  input  wire logic         pin_i,
  output logic              pin_o,
  output logic              pin_oe_o,
  // control table write
  output logic              ctrl_we_o,
  output logic [6:0]        ctrl_idx_o
);

  ////////////////////////////////////////////////////////////////////
  // role decode
  wire       used_w   = (map_i != `OCPM_MAP_UNUSED);
  wire       status_w = map_i[`OCPM_ROLE_BIT];
  wire [6:0] idx_w    = map_i[`OCPM_IDX_MSB:0];

  // control role writes the pin level into the table each clock that ce_i is high
  assign ctrl_we_o  = used_w && !status_w && ce_i;
  assign ctrl_idx_o = idx_w;

  // status role drives the addressed status bit
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_o    <= status_w ? stat_table_i[idx_w] : 1'b0;
      pin_oe_o <= used_w && status_w;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_status_pin_drive:
  assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && used_w && status_w) |=>
      (pin_oe_o && pin_o == $past(stat_table_i[idx_w])))
  else $error("status pin not driven from table");

  a_control_no_drive:
  assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && !status_w) |=> !pin_oe_o)
  else $error("control pin driven");

endmodule

/* File: ocpm_regs_test.sv */
// ocpm_regs_test.sv: self-checking bench for the phase and pin map slice
// assumes: ocpm_pkg compiled first; bench drives every port of ocpm_regs
`timescale 1ns/10ps
`include "ocpm_map.svh"
module ocpm_regs_test
  import ocpm_pkg::*;
;
  logic         clk_i, srst_i, ce_i, reg_wr_i, reg_rd_i;
  ocpm_byte_t   reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic         reg_rvalid_o, osc_drv_en_o;
  ocpm_coarse_t ph_coarse_o [3];
  ocpm_deg_t    ph_quad_deg_o [3];
  logic [2:0]   ph_delay_o, ph_advance_o, ph_update_o;
  logic [2:0]   pin_i, pin_o, pin_oe_o;
  logic [1:0]   chip_rev_hi_i;
  logic [9:0]   full_revision_o;
  logic [127:0] stat_table_i, ctrl_table_o, exp_tbl;
  logic [15:0]  v;
  logic [15:0]  old [3];
  int           err_count, total_checks, cyc, k;
  // test tables: coarse counts, expected degrees, reset image
  ocpm_coarse_t ctab [8] = '{13'h1fff, 13'h0001, 13'h1000, 13'h0fff,
                             13'h0000, 13'h1ffe, 13'h0002, 13'h0005};
  ocpm_deg_t    dtab [8] = '{9'h000, 9'h1d3, 9'h1a6, 9'h179,
                             9'h0b4, 9'h087, 9'h05a, 9'h02d};
  ocpm_byte_t   hi_a [3] = '{`OCPM_ADDR_S0D_HI, `OCPM_ADDR_S1C_HI,
                             `OCPM_ADDR_S1D_HI};
  ocpm_byte_t   lo_a [3] = '{`OCPM_ADDR_S0D_LO, `OCPM_ADDR_S1C_LO,
                             `OCPM_ADDR_S1D_LO};
  ocpm_byte_t   ra [12] = '{8'hc1, 8'hc2, 8'hc3, 8'hc6, 8'hc7, 8'hc8,
                            8'hc9, 8'hca, 8'he0, 8'he1, 8'he2, 8'hd0};
  ocpm_byte_t   rv [12] = '{8'h00, 8'h00, 8'h00, `OCPM_REV_DEFAULT, 8'h00,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00};

  ////////////////////////////////////////////////////////////////////////
  // device under test
  ocpm_regs uut (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .ph_coarse_o(ph_coarse_o),
    .ph_quad_deg_o(ph_quad_deg_o), .ph_delay_o(ph_delay_o),
    .ph_advance_o(ph_advance_o), .ph_update_o(ph_update_o),
    .osc_drv_en_o(osc_drv_en_o), .chip_rev_hi_i(chip_rev_hi_i),
    .full_revision_o(full_revision_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .stat_table_i(stat_table_i),
    .ctrl_table_o(ctrl_table_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare, host port cycles, reset, verdict
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input ocpm_byte_t a, input ocpm_byte_t d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // read answers at the taking edge; checked 1 ns after it
  task automatic rd(input ocpm_byte_t a, input ocpm_byte_t e);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rvalid_o, 1'b1);
    chk(reg_rdata_o, e);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
  endtask

  task automatic wait_pins();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    srst_i        = 1'b1;
    ce_i          = 1'b1;
    reg_wr_i      = 1'b0;
    reg_rd_i      = 1'b0;
    reg_addr_i    = 8'h00;
    reg_wdata_i   = 8'h00;
    chip_rev_hi_i = 2'b10;
    pin_i         = 3'b000;
    stat_table_i  = '0;
    err_count     = 0;
    total_checks  = 0;
    cyc           = 0;
    old           = '{16'h0000, 16'h0000, 16'h0000};
    do_reset();
    // reset image of every register and outputs
    chk(osc_drv_en_o, 1'b1);
    chk({ph_coarse_o[0], ph_coarse_o[1], ph_coarse_o[2]}, 39'h0);
    for (int i = 0; i < 12; i++)
      rd(ra[i], rv[i]);
    // every quarter code, split writes in both byte orders
    for (int q = 0; q < 8; q++)
    begin
      k = q % 3;
      v = {q[2:0], ctab[q]};
      wr(q[0] ? lo_a[k] : hi_a[k], q[0] ? v[7:0] : v[15:8]);
      chk(ph_update_o, 3'b000);
      rd(hi_a[k], old[k][15:8]);
      wr(q[0] ? hi_a[k] : lo_a[k], q[0] ? v[15:8] : v[7:0]);
      chk(ph_update_o, 3'b001 << k);
      chk(ph_coarse_o[k], ctab[q]);
      chk(ph_quad_deg_o[k], dtab[q]);
      chk(ph_delay_o[k], ctab[q][12]);
      chk(ph_advance_o[k], ctab[q] != 0 && !ctab[q][12]);
      chk(ph_coarse_o[(k + 1) % 3],
          ocpm_coarse_t'(old[(k + 1) % 3][12:0]));
      rd(lo_a[k], v[7:0]);
      old[k] = v;
    end
    // oscillator driver, revision, unmapped place
    wr(`OCPM_ADDR_OSC_SEL, 8'hff);
    chk(osc_drv_en_o, 1'b0);
    rd(`OCPM_ADDR_OSC_SEL, 8'h01);
    wr(`OCPM_ADDR_REV, 8'h00);
    wr(8'hd0, 8'h5a);
    rd(`OCPM_ADDR_REV, `OCPM_REV_DEFAULT);
    rd(8'hd0, 8'h00);
    chk(full_revision_o, {2'b10, `OCPM_REV_DEFAULT});
    @(posedge clk_i);
    chip_rev_hi_i <= 2'b01;
    #1;
    chk(full_revision_o, {2'b01, `OCPM_REV_DEFAULT});
    // disabled clock drops a write
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`OCPM_ADDR_PIN0, 8'h85);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(`OCPM_ADDR_PIN0, 8'h00);
    // pin maps: default control of bit 96, then status and top index
    @(posedge clk_i);
    pin_i <= 3'b111;
    wait_pins();
    exp_tbl     = '0;
    exp_tbl[96] = 1'b1;
    chk(ctrl_table_o, exp_tbl);
    chk(pin_oe_o, 3'b000);
    @(posedge clk_i);
    stat_table_i[5] <= 1'b1;
    wr(`OCPM_ADDR_PIN0, 8'h85);
    wr(`OCPM_ADDR_PIN1, 8'h7f);
    wait_pins();
    exp_tbl[127] = 1'b1;
    chk(pin_oe_o, 3'b001);
    chk(pin_o[0], 1'b1);
    chk(ctrl_table_o, exp_tbl);
    @(posedge clk_i);
    pin_i           <= 3'b001;
    stat_table_i[5] <= 1'b0;
    wait_pins();
    chk(ctrl_table_o, 128'h0);
    chk(pin_o[0], 1'b0);
    // second reset in mid-run
    @(posedge clk_i);
    pin_i <= 3'b000;
    do_reset();
    chk(osc_drv_en_o, 1'b1);
    chk(ph_coarse_o[2], 13'h0000);
    rd(`OCPM_ADDR_PIN0, 8'h00);
    rd(`OCPM_ADDR_PIN2, 8'h60);
    chk(pin_oe_o, 3'b000);
    tally_and_finish();
  end
endmodule
